// file: rsq_board_model.sv
// Board side of the reset pin: weak pull-up and an external pull-down
`timescale 1ns/1ps

module rsq_board_model (
    input wire logic i_clk, // CPU clock
    input wire logic i_pin_out, // Device pin value
    input wire logic i_pin_oe, // Device drives the pin
    input wire logic [7:0] i_pulse_len, // External low time in cycles
    input wire logic i_pulse_go, // Start an external pulse
    output logic o_pin // Resolved pin level
);
    logic [7:0] left = 8'h00;

    always @(posedge i_clk) begin
        if (i_pulse_go) begin
            left <= i_pulse_len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end

    // Pull-up wins only when nobody pulls the line low
    assign o_pin = i_pin_oe ? i_pin_out : (left == 8'h00);
endmodule : rsq_board_model

// file: rsq_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef RSQ_DEFS_SVH
`define RSQ_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define RSQ_CLK_NS 40
`define RSQ_T_OUT_LOW_NS 20000
`define RSQ_T_IN_LOW_NS 2500
`define RSQ_OUT_LOW_CYC ((`RSQ_T_OUT_LOW_NS + `RSQ_CLK_NS - 1) / `RSQ_CLK_NS)
`define RSQ_IN_LOW_CYC (`RSQ_T_IN_LOW_NS / `RSQ_CLK_NS)
`define RSQ_STAB_CYC 4096
`define RSQ_FETCH_CYC 2

// ----------------------------------------------------------------
// Reset vector
// ----------------------------------------------------------------
`define RSQ_VEC_LO 16'hFFFE
`define RSQ_VEC_HI 16'hFFFF

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RSQ_ADDR_CAUSE 8'h00
`define RSQ_ADDR_STATUS 8'h04
`define RSQ_ADDR_MASK 8'h08
`define RSQ_ADDR_INFO 8'h0C

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define RSQ_CAUSE_SUPPLY 4
`define RSQ_CAUSE_WDG 0
`define RSQ_EVT_SUPPLY 0
`define RSQ_EVT_EXT 1
`define RSQ_EVT_WDG 2
`define RSQ_EVT_DONE 3
`define RSQ_EVT_RST 4'h0
`define RSQ_MASK_RST 4'h0

// ----------------------------------------------------------------
// Clock source option codes
// ----------------------------------------------------------------
`define RSQ_SRC_EXT 3'h0
`define RSQ_SRC_RES0 3'h1
`define RSQ_SRC_RES3 3'h4
`define RSQ_SRC_ERC 3'h5
`define RSQ_SRC_IRC 3'h6

`endif

// file: rsq_pkg.sv
// Types shared by the reset sequencer modules
package rsq_pkg;

    typedef enum logic [2:0] {
        PH_DRIVE,
        PH_WAIT_PIN,
        PH_STAB,
        PH_FETCH,
        PH_RUN
    } rsq_phase_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rsq_bus_req_type;

    typedef struct packed {
        rsq_phase_type phase;
        logic [12:0] cnt;
        logic [12:0] in_cnt;
        logic pin_oe;
        logic core_rst;
        logic vec_fetch;
        logic [15:0] vec_addr;
        logic supply_flag;
        logic wdg_flag;
        logic [3:0] status;
        logic [3:0] mask;
        logic irq;
        logic [7:0] rdata;
        logic [1:0] lvd_level;
        logic [2:0] clk_src;
        logic osc_run;
    } rsq_state_type;

endpackage : rsq_pkg

// file: rsq_reset_sequencer.sv
// Reset sequencer: source merge, pin drive, phases, cause flags
//
// What this block does
// - Hold static reset while the supply is below its threshold.
// - Supply detection uses higher rising and lower falling thresholds.
// - Drive the reset pin low during a supply-drop reset.
// - Supply-drop flag set by hardware, cleared only by software writing zero.
// - Pin, supply and watchdog sources all drive the pin low in delay phase.
// - Core fetches its start address from the top two vector bytes.
// - Phases run in order: source delay, 4096-cycle settle, vector fetch.
// - Vector fetch lasts exactly two clock cycles.
// - Reset pin is open-drain output and input with weak pull-up.
// - External low pulse of minimum width is recognised as reset.
// - After an external pulse, drive pin low for minimum output time.
// - Watchdog underflow drives pin low minimum time, then sequence.
// - Supply threshold level comes from option byte, not a register.
// - Clock source chosen by option byte among seven sources.
// - Resonator oscillators keep running through the reset phase.
// - Watchdog flag set by watchdog reset, cleared by zero write or drop.
// - Supply-drop flag survives later external and watchdog resets.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "rsq_defs.svh"

module rsq_reset_sequencer #(
    parameter int STAB_CYC = `RSQ_STAB_CYC,
    parameter int OUT_LOW_CYC = `RSQ_OUT_LOW_CYC,
    parameter int IN_LOW_CYC = `RSQ_IN_LOW_CYC
) (
    input wire logic i_clk, // CPU clock, 25 MHz
    input wire logic i_rst_b, // Power-on reset, async, active low
    input wire logic i_pin_rst_in, // Reset pin level at pad
    output logic o_pin_rst_out, // Reset pin output value
    output logic o_pin_rst_oe, // Reset pin driven low when high
    input wire logic i_vdd_rise_ok, // Supply above rising threshold
    input wire logic i_vdd_fall_ok, // Supply above falling threshold
    input wire logic i_wdg_underflow, // Watchdog underflow pulse
    input wire logic [1:0] i_opt_lvd_level, // Option byte threshold
    input wire logic [2:0] i_opt_clk_src, // Option byte clock source
    output logic [1:0] o_lvd_level, // Threshold level to detector
    output logic [2:0] o_clk_src, // Clock source select
    output logic o_osc_run, // Oscillator enable
    output logic o_core_rst, // Core held in reset
    output logic o_vec_fetch, // Vector fetch phase
    output logic [15:0] o_vec_addr, // Vector address in fetch
    input wire rsq_pkg::rsq_bus_req_type i_bus, // Register request
    output logic [7:0] o_rdata, // Read data, cycle after read
    output logic o_irq // Interrupt, level
);
    import rsq_pkg::*;

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam logic [12:0] STAB_M1 = 13'(STAB_CYC - 1);
    localparam logic [12:0] OUT_M1 = 13'(OUT_LOW_CYC - 1);
    localparam logic [12:0] IN_M1 = 13'(IN_LOW_CYC - 1);
    localparam logic [12:0] FETCH_M1 = 13'(`RSQ_FETCH_CYC - 1);

    rsq_state_type s;
    rsq_state_type next_s;

    logic [2:0] sync_q;
    logic pin_hi;
    logic rise_ok;
    logic fall_ok;
    logic sup_low;
    logic sup_drop;
    logic ext_rec;
    logic any_src;
    logic wr_cause;
    logic wr_status;
    logic wr_mask;
    logic resonator;
    logic [3:0] events;

    // ----------------------------------------------------------------
    // Input synchronisers and supply detector
    // ----------------------------------------------------------------
    // Pad levels come from outside the clock domain
    rsq_sync #(
        .W(3),
        .RST_VAL(3'h0)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_pin_rst_in, i_vdd_rise_ok, i_vdd_fall_ok}),
        .o_sync(sync_q)
    );

    assign pin_hi = sync_q[2];
    assign rise_ok = sync_q[1];
    assign fall_ok = sync_q[0];

    rsq_supply_mon u_mon (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_rise_ok(rise_ok),
        .i_fall_ok(fall_ok),
        .o_low(sup_low),
        .o_drop(sup_drop)
    );

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] rd_mux(input logic [7:0] addr,
                                          input rsq_state_type st,
                                          input logic low);
        logic [7:0] d;
        d = 8'h00;
        case (addr)
            `RSQ_ADDR_CAUSE: begin
                d[`RSQ_CAUSE_SUPPLY] = st.supply_flag;
                d[`RSQ_CAUSE_WDG] = st.wdg_flag;
            end
            `RSQ_ADDR_STATUS: d[3:0] = st.status;
            `RSQ_ADDR_MASK: d[3:0] = st.mask;
            `RSQ_ADDR_INFO: d = {low, st.lvd_level, st.clk_src, 2'h0};
            default: d = 8'h00;
        endcase
        return d;
    endfunction : rd_mux

    assign wr_cause = i_bus.wr && (i_bus.addr == `RSQ_ADDR_CAUSE);
    assign wr_status = i_bus.wr && (i_bus.addr == `RSQ_ADDR_STATUS);
    assign wr_mask = i_bus.wr && (i_bus.addr == `RSQ_ADDR_MASK);
    assign resonator = (s.clk_src >= `RSQ_SRC_RES0)
                       && (s.clk_src <= `RSQ_SRC_RES3);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        ext_rec = 1'b0;

        // Pin is only watched while not driven by us and not awaited
        if (s.phase == PH_STAB || s.phase == PH_FETCH
            || s.phase == PH_RUN) begin
            if (pin_hi) begin
                next_s.in_cnt = 13'h0000;
            end else if (s.in_cnt == IN_M1) begin
                ext_rec = 1'b1;
                next_s.in_cnt = 13'h0000;
            end else begin
                next_s.in_cnt = s.in_cnt + 13'h0001;
            end
        end else begin
            next_s.in_cnt = 13'h0000;
        end

        any_src = sup_low || i_wdg_underflow || ext_rec;

        if (any_src) begin
            // Supply low keeps restarting the count: static reset
            next_s.phase = PH_DRIVE;
            next_s.cnt = 13'h0000;
        end else begin
            case (s.phase)
                PH_DRIVE: begin
                    if (s.cnt == OUT_M1) begin
                        next_s.phase = PH_WAIT_PIN;
                        next_s.cnt = 13'h0000;
                    end else begin
                        next_s.cnt = s.cnt + 13'h0001;
                    end
                end
                PH_WAIT_PIN: begin
                    // A long external pulse holds us here
                    if (pin_hi) begin
                        next_s.phase = PH_STAB;
                        next_s.cnt = 13'h0000;
                    end
                end
                PH_STAB: begin
                    if (s.cnt == STAB_M1) begin
                        next_s.phase = PH_FETCH;
                        next_s.cnt = 13'h0000;
                    end else begin
                        next_s.cnt = s.cnt + 13'h0001;
                    end
                end
                PH_FETCH: begin
                    if (s.cnt == FETCH_M1) begin
                        next_s.phase = PH_RUN;
                        next_s.cnt = 13'h0000;
                    end else begin
                        next_s.cnt = s.cnt + 13'h0001;
                    end
                end
                PH_RUN: next_s.cnt = 13'h0000;
                default: begin
                    next_s.phase = PH_DRIVE;
                    next_s.cnt = 13'h0000;
                end
            endcase
        end

        // Outputs follow the phase being entered
        next_s.pin_oe = (next_s.phase == PH_DRIVE);
        next_s.core_rst = (next_s.phase == PH_DRIVE)
                          || (next_s.phase == PH_WAIT_PIN)
                          || (next_s.phase == PH_STAB);
        next_s.vec_fetch = (next_s.phase == PH_FETCH);
        if (next_s.phase == PH_FETCH) begin
            next_s.vec_addr = (next_s.cnt == 13'h0000) ? `RSQ_VEC_LO
                                                       : `RSQ_VEC_HI;
        end else begin
            next_s.vec_addr = 16'h0000;
        end

        // Option bytes are read only while the pin is driven
        if (next_s.phase == PH_DRIVE) begin
            next_s.lvd_level = i_opt_lvd_level;
            next_s.clk_src = i_opt_clk_src;
        end
        // RC and external sources may stop in reset, resonators not
        next_s.osc_run = ((next_s.clk_src >= `RSQ_SRC_RES0)
                          && (next_s.clk_src <= `RSQ_SRC_RES3))
                         || !next_s.core_rst;

        // Cause flags: zero write clears, hardware set wins
        if (wr_cause && !i_bus.wdata[`RSQ_CAUSE_SUPPLY]) begin
            next_s.supply_flag = 1'b0;
        end
        if (wr_cause && !i_bus.wdata[`RSQ_CAUSE_WDG]) begin
            next_s.wdg_flag = 1'b0;
        end
        // Only a supply-drop touches this flag from hardware
        if (sup_low) begin
            next_s.supply_flag = 1'b1;
            next_s.wdg_flag = 1'b0;
        end else if (i_wdg_underflow) begin
            next_s.wdg_flag = 1'b1;
        end

        // Interrupt status, write one to clear, set wins
        events = 4'h0;
        events[`RSQ_EVT_SUPPLY] = sup_drop;
        events[`RSQ_EVT_EXT] = ext_rec;
        events[`RSQ_EVT_WDG] = i_wdg_underflow;
        events[`RSQ_EVT_DONE] = (s.phase == PH_FETCH)
                                && (next_s.phase == PH_RUN);
        if (wr_status) begin
            next_s.status = s.status & ~i_bus.wdata[3:0];
        end
        next_s.status = next_s.status | events;
        if (wr_mask) begin
            next_s.mask = i_bus.wdata[3:0];
        end
        next_s.irq = |(next_s.status & next_s.mask);

        next_s.rdata = i_bus.rd ? rd_mux(i_bus.addr, s, sup_low) : 8'h00;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '{phase: PH_DRIVE, cnt: 13'h0000, in_cnt: 13'h0000,
                   pin_oe: 1'b1, core_rst: 1'b1, vec_fetch: 1'b0,
                   vec_addr: 16'h0000, supply_flag: 1'b0,
                   wdg_flag: 1'b0, status: `RSQ_EVT_RST,
                   mask: `RSQ_MASK_RST, irq: 1'b0, rdata: 8'h00,
                   lvd_level: 2'h0, clk_src: `RSQ_SRC_EXT,
                   osc_run: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    // Open drain: only ever pulls low
    assign o_pin_rst_out = 1'b0;
    assign o_pin_rst_oe = s.pin_oe;
    assign o_lvd_level = s.lvd_level;
    assign o_clk_src = s.clk_src;
    assign o_osc_run = s.osc_run;
    assign o_core_rst = s.core_rst;
    assign o_vec_fetch = s.vec_fetch;
    assign o_vec_addr = s.vec_addr;
    assign o_rdata = s.rdata;
    assign o_irq = s.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [12:0] oe_len;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            oe_len <= 13'h0001;
        end else if (s.pin_oe && next_s.pin_oe) begin
            // Saturate so a long static reset cannot wrap the count
            if (oe_len != 13'h1FFF) begin
                oe_len <= oe_len + 13'h0001;
            end
        end else if (next_s.pin_oe) begin
            oe_len <= 13'h0001;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_static_hold: assert property (sup_low |=> s.pin_oe && s.cnt == 0)
        else $error("Supply low did not hold static reset");
    a_pin_delay: assert property (s.phase == PH_DRIVE |-> o_pin_rst_oe)
        else $error("Pin not driven in delay phase");
    a_out_low_min: assert property ($fell(s.pin_oe) |-> oe_len >= 13'(OUT_LOW_CYC))
        else $error("Pin released before minimum low time");
    a_wdg_drive: assert property (i_wdg_underflow |=> s.pin_oe && s.cnt == 0)
        else $error("Watchdog underflow did not restart delay");
    a_stab_order: assert property ($rose(s.phase == PH_STAB) |-> $past(s.phase) == PH_WAIT_PIN && $past(pin_hi))
        else $error("Settle count started early");
    a_stab_end: assert property (s.phase == PH_STAB && s.cnt == STAB_M1 && !any_src |=> s.vec_fetch && s.vec_addr == `RSQ_VEC_LO)
        else $error("Fetch did not follow settle count");
    a_fetch_two: assert property (s.phase == PH_FETCH && s.cnt == 0 && !any_src ##1 !any_src |=> s.phase == PH_RUN && !s.vec_fetch)
        else $error("Fetch phase not two cycles");
    a_vec_addr: assert property (s.vec_fetch |-> s.vec_addr[15:1] == 15'h7FFF && s.core_rst == 1'b0)
        else $error("Fetch outside vector location");
    a_sup_flag: assert property (sup_low |=> s.supply_flag && !s.wdg_flag)
        else $error("Supply drop flags wrong");
    a_flag_keep: assert property (s.supply_flag && !(wr_cause && !i_bus.wdata[`RSQ_CAUSE_SUPPLY]) |=> s.supply_flag)
        else $error("Supply flag lost");
    a_wdg_flag: assert property (i_wdg_underflow && !sup_low |=> s.wdg_flag)
        else $error("Watchdog flag not set");
    a_osc_keep: assert property (resonator |-> s.osc_run)
        else $error("Resonator stopped in reset");

    c_full_seq: cover property (s.phase == PH_STAB ##1 s.phase == PH_FETCH [*2] ##1 s.phase == PH_RUN);
    c_ext_pulse: cover property (s.phase == PH_RUN ##1 ext_rec);
    c_wdg_reset: cover property (s.phase == PH_RUN && i_wdg_underflow);
    c_irq: cover property ($rose(o_irq));

endmodule : rsq_reset_sequencer

// file: rsq_supply_mon.sv
// Supply-drop detector with rising and falling thresholds
`timescale 1ns/1ps

module rsq_supply_mon (
    input wire logic i_clk, // CPU clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_rise_ok, // Supply above rising threshold
    input wire logic i_fall_ok, // Supply above falling threshold
    output logic o_low, // Supply counted as low
    output logic o_drop // Pulse on entry into low
);
    import rsq_pkg::*;

    typedef struct packed {
        logic low;
        logic drop;
    } rsq_mon_type;

    rsq_mon_type s;
    rsq_mon_type next_s;

    // Gap between thresholds keeps core start-up current from retriggering
    always_comb begin
        next_s = s;
        if (s.low) begin
            next_s.low = !i_rise_ok;
        end else begin
            next_s.low = !i_fall_ok;
        end
        next_s.drop = !s.low && next_s.low;
    end

    // Power-up starts as low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '{low: 1'b1, drop: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign o_low = s.low;
    assign o_drop = s.drop;

endmodule : rsq_supply_mon

// file: rsq_sync.sv
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps

module rsq_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_clk, // CPU clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic [W-1:0] i_async, // Levels from outside
    output logic [W-1:0] o_sync // Synchronised levels
);
    import rsq_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rsq_sync_type;

    rsq_sync_type s;
    rsq_sync_type next_s;

    always_comb begin
        next_s.s1 = i_async;
        next_s.s2 = s.s1;
    end

    // Reset level fixed at elaboration keeps the reset branch constant
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign o_sync = s.s2;

endmodule : rsq_sync

// file: testbench.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`include "rsq_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end

module testbench;
    import rsq_pkg::*;
    // Short counts keep the run brief
    localparam int STAB = 8;
    localparam int OUTL = 4;
    localparam int INL = 2;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic pin, pout, oe, rise_ok = 1'b0, fall_ok = 1'b0, wdg = 1'b0;
    logic osc, core_rst, vf, irq, pgo = 1'b0;
    logic [1:0] supply_drop_detector;
    logic [2:0] src, opt_src = `RSQ_SRC_RES0;
    logic [15:0] va;
    logic [7:0] rdata, d, plen = 8'h00;
    rsq_bus_req_type bus = '0;
    int fail_count = 0;
    int checks = 0;
    int n;

    always #20 i_clk = ~i_clk;

    rsq_reset_sequencer #(.STAB_CYC(STAB), .OUT_LOW_CYC(OUTL),
        .IN_LOW_CYC(INL)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_pin_rst_in(pin), .o_pin_rst_out(pout), .o_pin_rst_oe(oe),
        .i_vdd_rise_ok(rise_ok), .i_vdd_fall_ok(fall_ok),
        .i_wdg_underflow(wdg), .i_opt_lvd_level(2'h2),
        .i_opt_clk_src(opt_src), .o_lvd_level(supply_drop_detector), .o_clk_src(src),
        .o_osc_run(osc), .o_core_rst(core_rst), .o_vec_fetch(vf),
        .o_vec_addr(va), .i_bus(bus), .o_rdata(rdata), .o_irq(irq));

    rsq_board_model u_board (.i_clk(i_clk), .i_pin_out(pout),
        .i_pin_oe(oe), .i_pulse_len(plen), .i_pulse_go(pgo), .o_pin(pin));

    task automatic report_and_stop;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus <= '0;
        @(negedge i_clk);
        v = rdata;
    endtask : rd

    task automatic give_up;
        fail_count++;
        $display("unexpected t=%0t wait ran out", $time);
        report_and_stop();
    endtask : give_up

    // Cycles the pin stays driven, from the next falling edge on
    task automatic oe_len(output int c);
        c = 0;
        @(negedge i_clk);
        while (oe === 1'b1) begin
            c++;
            if (c > 100) give_up();
            @(negedge i_clk);
        end
    endtask : oe_len

    task automatic wait_fetch(output int c);
        c = 0;
        @(negedge i_clk);
        while (vf !== 1'b1) begin
            c++;
            if (c > 200) give_up();
            @(negedge i_clk);
        end
        `CHK(core_rst, 1'b0)
        `CHK(va, `RSQ_VEC_LO)
        @(negedge i_clk);
        `CHK(vf, 1'b1)
        `CHK(va, `RSQ_VEC_HI)
        @(negedge i_clk);
        `CHK(vf, 1'b0)
        `CHK(core_rst, 1'b0)
    endtask : wait_fetch

    task automatic test_power_up;
        repeat (6) @(negedge i_clk);
        `CHK(oe, 1'b1)
        @(posedge i_clk);
        fall_ok <= 1'b1;
        repeat (10) @(negedge i_clk);
        `CHK(oe, 1'b1)
        @(posedge i_clk);
        rise_ok <= 1'b1;
        oe_len(n);
        wait_fetch(n);
        `CHK(n >= STAB, 1'b1)
        `CHK(supply_drop_detector, 2'h2)
        `CHK(src, `RSQ_SRC_RES0)
        rd(`RSQ_ADDR_CAUSE, d);
        `CHK(d, 8'h10)
        $display("power-up done");
    endtask : test_power_up

    task automatic test_watchdog;
        @(posedge i_clk);
        wdg <= 1'b1;
        @(posedge i_clk);
        wdg <= 1'b0;
        @(negedge i_clk);
        `CHK(oe, 1'b1)
        `CHK(osc, 1'b1)
        oe_len(n);
        `CHK(n + 1 >= OUTL, 1'b1)
        wait_fetch(n);
        rd(`RSQ_ADDR_CAUSE, d);
        `CHK(d, 8'h11)
        $display("watchdog done");
    endtask : test_watchdog

    task automatic test_supply_drop;
        @(posedge i_clk);
        rise_ok <= 1'b0;
        opt_src <= `RSQ_SRC_IRC;
        repeat (10) @(negedge i_clk);
        `CHK(core_rst, 1'b0)
        @(posedge i_clk);
        fall_ok <= 1'b0;
        repeat (6) @(negedge i_clk);
        `CHK(oe, 1'b1)
        `CHK(core_rst, 1'b1)
        `CHK(osc, 1'b0)
        `CHK(src, `RSQ_SRC_IRC)
        @(posedge i_clk);
        fall_ok <= 1'b1;
        repeat (10) @(negedge i_clk);
        `CHK(oe, 1'b1)
        @(posedge i_clk);
        rise_ok <= 1'b1;
        wait_fetch(n);
        rd(`RSQ_ADDR_CAUSE, d);
        `CHK(d, 8'h10)
        $display("supply drop done");
    endtask : test_supply_drop

    task automatic test_external;
        wr(`RSQ_ADDR_CAUSE, 8'h00);
        rd(`RSQ_ADDR_CAUSE, d);
        `CHK(d, 8'h00)
        @(posedge i_clk);
        plen <= 8'(INL + 3);
        pgo <= 1'b1;
        @(posedge i_clk);
        pgo <= 1'b0;
        n = 0;
        while (oe !== 1'b1) begin
            n++;
            if (n > 20) give_up();
            @(negedge i_clk);
        end
        oe_len(n);
        `CHK(n + 1 >= OUTL, 1'b1)
        wait_fetch(n);
        rd(`RSQ_ADDR_CAUSE, d);
        `CHK(d, 8'h00)
        $display("external pulse done");
    endtask : test_external

    task automatic test_irq;
        rd(`RSQ_ADDR_STATUS, d);
        `CHK(d, 8'h0F)
        `CHK(irq, 1'b0)
        wr(`RSQ_ADDR_MASK, 8'h02);
        @(negedge i_clk);
        `CHK(irq, 1'b1)
        wr(`RSQ_ADDR_STATUS, 8'h02);
        @(negedge i_clk);
        `CHK(irq, 1'b0)
        rd(`RSQ_ADDR_STATUS, d);
        `CHK(d, 8'h0D)
        rd(8'h10, d);
        `CHK(d, 8'h00)
        rd(`RSQ_ADDR_INFO, d);
        `CHK(d, 8'h58)
        $display("interrupt done");
    endtask : test_irq

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        test_power_up();
        test_watchdog();
        test_supply_drop();
        test_external();
        test_irq();
        report_and_stop();
    end
endmodule : testbench
